// [rtl/spi_unit_pkg.sv]
// constants and state types shared by the serial unit and its rate generator
`default_nettype none

package spi_unit_pkg;

	////////////////////////////////////////////////////////////////////////
	// character and rate generator sizes
	localparam int CHAR_BITS = 8;
	localparam int RATE_BITS = 16;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [7:0] ALL_ONES = 8'hff;

	////////////////////////////////////////////////////////////////////////
	// unit enable pair codes
	localparam logic [1:0] PAIR_OFF = 2'h0;
	localparam logic [1:0] PAIR_RX_ONLY = 2'h1;
	localparam logic [1:0] PAIR_TX_ONLY = 2'h2;

	// protocol select field codes
	localparam logic [2:0] PROTO_PLAIN = 3'h0;
	localparam logic [2:0] PROTO_AUDIO = 3'h2;
	localparam int PROTO_FRAMED_BIT = 1;

	////////////////////////////////////////////////////////////////////////
	// shift engine states
	typedef enum logic [1:0]
	{
		ENG_IDLE = 2'b00,
		ENG_MASTER = 2'b01,
		ENG_SLAVE = 2'b10
	} engine_e;

	// whole state of the serial unit
	typedef struct packed
	{
		engine_e engine;
		logic [7:0] tx_hold;
		logic [7:0] shift;
		logic [7:0] rx_hold;
		logic [3:0] bit_count;
		logic tx_loaded;
		logic rx_full;
		logic underrun;
		logic collision;
		logic abort;
		logic overrun;
		logic select_value;
		logic end_of_frame;
		logic frame_last;
		logic rx_select;
		logic sck;
		logic out_bit;
		logic sck_prev;
		logic sel_n_prev;
		logic sel_prev;
		logic done;
		logic [5:0] irq_prev;
		logic irq;
	} unit_state_s;

	localparam unit_state_s UNIT_RESET = '0;

	// whole state of the rate generator
	typedef struct packed
	{
		logic [RATE_BITS-1:0] count;
	} rate_state_s;

	localparam rate_state_s RATE_RESET = '0;

endpackage : spi_unit_pkg

`default_nettype wire

// [rtl/rate_generator.sv]
// reloading down counter that paces the serial clock and the timer
`default_nettype none

module rate_generator
	import spi_unit_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [RATE_BITS-1:0] reload_i,
	input wire logic run_i,
	input wire logic restart_i,
	output logic tick_o
);

	rate_state_s state;
	rate_state_s next_state;
	logic [RATE_BITS-1:0] reload_less;

	////////////////////////////////////////////////////////////////////////
	// zero reload wraps to all ones, giving a full 65536 cycle span
	assign reload_less = reload_i - 16'h0001;
	assign tick_o = run_i && (state.count == 16'h0000);

	// count down, reload on expiry, restart or idle
	always_comb
	begin
		next_state = state;
		if (restart_i || !run_i || tick_o)
		begin
			next_state.count = reload_less;
		end
		else
		begin
			next_state.count = state.count - 16'h0001;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			state <= RATE_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

endmodule : rate_generator

`default_nettype wire

// [rtl/spi_errors_irq_dma.sv]
// serial unit: shift engines, error flags, interrupt pulse and dma handshake
`default_nettype none

// How it works
// - errors interrupt; each flag cleared by writing one
// - framed master underrun halts clock, drops select
// - plain master pauses instead of flagging underrun
// - slave start with empty transmit sends ones
// - master with select input low flags collision
// - overrun keeps old byte, drops new data
// - slave deselect mid character aborts to idle
// - slave rate counter watchdog reloads on clock edges
// - one cycle interrupt pulse on source rise
// - data interrupts gated by enable, errors not
// - transmit empty clears on write, sets on load
// - receive only hides transmit interrupts, write starts
// - character end loads receive data, sets full
// - transmit only hides receive interrupts
// - disabled timer timeout interrupts without status flags
// - dma requests from flags, done on deselect
// - slave receive only transmits all ones
// - descriptor select loads first byte, eof clears
// - receive status holds select, abort, overrun
// - rate reload sixteen bits, zero means 65536
// - protocol field picks plain or framed audio
module spi_errors_irq_dma
	import spi_unit_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [1:0] unit_enable_pair_i,
	input wire logic master_select_i,
	input wire logic select_pin_direction_i,
	input wire logic [2:0] protocol_select_field_i,
	input wire logic data_irq_enable_i,
	input wire logic rate_timer_control_i,
	input wire logic [7:0] rate_high_i,
	input wire logic [7:0] rate_low_i,
	input wire logic tx_write_i,
	input wire logic [7:0] tx_data_i,
	input wire logic rx_read_i,
	input wire logic select_value_write_i,
	input wire logic select_value_i,
	input wire logic tx_end_of_frame_i,
	input wire logic clear_underrun_i,
	input wire logic clear_collision_i,
	input wire logic clear_abort_i,
	input wire logic clear_overrun_i,
	input wire logic tx_dma_ack_i,
	input wire logic rx_dma_ack_i,
	input wire logic dma_first_byte_i,
	input wire logic dma_select_value_i,
	input wire logic dma_end_of_frame_strobe_i,
	input wire logic serial_clock_i,
	input wire logic select_n_i,
	input wire logic data_in_i,
	output logic serial_clock_o,
	output logic serial_clock_oe_o,
	output logic select_n_o,
	output logic select_n_oe_o,
	output logic data_out_o,
	output logic data_out_oe_o,
	output logic [7:0] rx_data_o,
	output logic tx_empty_flag_o,
	output logic rx_full_flag_o,
	output logic tx_underrun_flag_o,
	output logic collision_flag_o,
	output logic slave_abort_flag_o,
	output logic rx_overrun_flag_o,
	output logic select_value_o,
	output logic tx_end_of_frame_o,
	output logic [3:0] rx_descriptor_status_o,
	output logic tx_dma_request_o,
	output logic rx_dma_request_o,
	output logic tx_dma_done_o,
	output logic rx_dma_done_o,
	output logic irq_o
);

	unit_state_s state;
	unit_state_s next_state;
	logic enabled, plain, framed, tx_empty, tx_accept, rx_take;
	logic master_start, watchdog_run, timer_run, rate_run, rate_restart;
	logic rate_tick, sck_rise, sck_fall, sel_fall, sel_active;
	logic char_done, ev_under, ev_col, ev_abort, ev_over;
	logic tx_gated, rx_gated;
	logic [7:0] captured, slave_load;
	logic [5:0] sources;

	// set wins over a write-one clear in the same cycle
	function automatic logic flag_update(input logic old, input logic clr,
		input logic set);
		flag_update = (old && !clr) || set;
	endfunction : flag_update

	////////////////////////////////////////////////////////////////////////
	// mode decode
	assign enabled = unit_enable_pair_i != PAIR_OFF;
	assign plain = protocol_select_field_i == PROTO_PLAIN;
	assign framed = protocol_select_field_i[PROTO_FRAMED_BIT];
	assign tx_empty = enabled && !state.tx_loaded;
	assign tx_accept = (tx_write_i || tx_dma_ack_i) && tx_empty;
	assign rx_take = rx_read_i || rx_dma_ack_i;

	// slave clock and select edges, pins are already synchronous
	assign sck_rise = serial_clock_i && !state.sck_prev;
	assign sck_fall = !serial_clock_i && state.sck_prev;
	assign sel_fall = !select_n_i && state.sel_n_prev;
	assign sel_active = master_select_i ? state.select_value : !select_n_i;

	// master starts a character only once data is written
	assign master_start = (state.engine == ENG_IDLE) && enabled
		&& master_select_i && state.tx_loaded
		&& !(plain && state.rx_full
		&& (unit_enable_pair_i != PAIR_TX_ONLY));

	// rate generator sharing: master clock, slave watchdog, disabled timer
	assign watchdog_run = enabled && !master_select_i
		&& rate_timer_control_i && !select_n_i;
	assign timer_run = !enabled && rate_timer_control_i;
	assign rate_run = (state.engine == ENG_MASTER) || watchdog_run
		|| timer_run;
	assign rate_restart = master_start
		|| (watchdog_run && (sck_rise || sck_fall || sel_fall));

	// slave source: ones when empty or receive only
	assign slave_load = (tx_empty || unit_enable_pair_i == PAIR_RX_ONLY)
		? ALL_ONES : state.tx_hold;
	assign captured = {state.shift[6:0], data_in_i};

	rate_generator u_rate
	(
		.clock_i(clock_i),
		.reset_i(reset_i),
		.reload_i({rate_high_i, rate_low_i}),
		.run_i(rate_run),
		.restart_i(rate_restart),
		.tick_o(rate_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// interrupt sources, data sources gated, errors always
	assign tx_gated = tx_empty && data_irq_enable_i
		&& (unit_enable_pair_i != PAIR_RX_ONLY);
	assign rx_gated = state.rx_full && data_irq_enable_i && enabled
		&& (unit_enable_pair_i != PAIR_TX_ONLY);
	assign sources = {tx_gated, state.underrun, state.collision,
		state.abort, state.overrun, rx_gated};

	////////////////////////////////////////////////////////////////////////
	// next state of the whole unit
	always_comb
	begin
		next_state = state;
		char_done = 1'b0;
		ev_under = 1'b0;
		ev_abort = 1'b0;
		ev_over = 1'b0;
		ev_col = 1'b0;
		next_state.sck_prev = serial_clock_i;
		next_state.sel_n_prev = select_n_i;
		// command bits from software and the dma
		if (select_value_write_i)
		begin
			next_state.select_value = select_value_i;
			next_state.end_of_frame = tx_end_of_frame_i;
		end
		if (tx_accept)
		begin
			next_state.tx_hold = tx_data_i;
			next_state.tx_loaded = 1'b1;
			if (dma_first_byte_i)
			begin
				next_state.select_value = dma_select_value_i;
			end
			if (dma_end_of_frame_strobe_i)
			begin
				next_state.end_of_frame = 1'b1;
			end
		end
		// shift engines
		unique case (state.engine)
			ENG_IDLE:
			begin
				if (master_start)
				begin
					next_state.engine = ENG_MASTER;
					next_state.shift = state.tx_hold;
					next_state.out_bit = state.tx_hold[7];
					next_state.tx_loaded = 1'b0;
					next_state.frame_last = state.end_of_frame;
					next_state.bit_count = 4'h0;
				end
				else if (enabled && !master_select_i && !select_n_i)
				begin
					next_state.engine = ENG_SLAVE;
					next_state.bit_count = 4'h0;
				end
			end
			ENG_MASTER:
			begin
				if (rate_tick && !state.sck)
				begin
					next_state.sck = 1'b1;
					next_state.out_bit = state.shift[7];
				end
				else if (rate_tick)
				begin
					next_state.sck = 1'b0;
					next_state.shift = captured;
					next_state.bit_count = state.bit_count + 4'h1;
					if (state.bit_count == LAST_BIT)
					begin
						char_done = 1'b1;
						next_state.engine = ENG_IDLE;
						next_state.bit_count = 4'h0;
						if (state.frame_last)
						begin
							next_state.select_value = 1'b0;
							next_state.end_of_frame = 1'b0;
						end
						else if (tx_empty && framed)
						begin
							ev_under = 1'b1;
							next_state.select_value = 1'b0;
						end
					end
				end
			end
			ENG_SLAVE:
			begin
				if (select_n_i || (watchdog_run && rate_tick))
				begin
					// deselect mid character or watchdog expiry
					ev_abort = !select_n_i
						|| (state.bit_count != 4'h0);
					next_state.engine = ENG_IDLE;
					next_state.bit_count = 4'h0;
				end
				else if (sck_rise && state.bit_count == 4'h0)
				begin
					next_state.shift = slave_load;
					next_state.out_bit = slave_load[7];
					next_state.tx_loaded = 1'b0;
					ev_under = tx_empty;
				end
				else if (sck_rise)
				begin
					next_state.out_bit = state.shift[7];
				end
				else if (sck_fall)
				begin
					next_state.shift = captured;
					next_state.bit_count = state.bit_count + 4'h1;
					if (state.bit_count == LAST_BIT)
					begin
						char_done = 1'b1;
						next_state.bit_count = 4'h0;
					end
				end
			end
			default:
			begin
				next_state.engine = ENG_IDLE;
			end
		endcase
		// disabling idles the engine, lowers the clock and empties transmit
		if (!enabled)
		begin
			next_state.engine = ENG_IDLE;
			next_state.tx_loaded = 1'b0;
			next_state.sck = 1'b0;
			next_state.bit_count = 4'h0;
		end
		// character end: receive or overrun
		if (char_done && state.rx_full)
		begin
			ev_over = !(master_select_i && plain);
		end
		else if (char_done)
		begin
			next_state.rx_hold = captured;
			next_state.rx_select = sel_active;
		end
		ev_col = enabled && master_select_i && !select_pin_direction_i
			&& !select_n_i;
		// status flags
		next_state.rx_full = flag_update(state.rx_full, rx_take,
			char_done && !state.rx_full);
		next_state.underrun = flag_update(state.underrun,
			clear_underrun_i, ev_under);
		next_state.collision = flag_update(state.collision,
			clear_collision_i, ev_col);
		next_state.abort = flag_update(state.abort, clear_abort_i,
			ev_abort);
		next_state.overrun = flag_update(state.overrun, clear_overrun_i,
			ev_over);
		// end of transaction toward the dma
		next_state.sel_prev = sel_active;
		next_state.done = state.sel_prev && !sel_active;
		// single pulse on any source rise, or on a timer expiry
		next_state.irq_prev = sources;
		next_state.irq = (|(sources & ~state.irq_prev))
			|| (timer_run && rate_tick);
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			state <= UNIT_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign serial_clock_o = state.sck;
	assign serial_clock_oe_o = enabled && master_select_i;
	assign select_n_o = !state.select_value;
	assign select_n_oe_o = enabled && master_select_i
		&& select_pin_direction_i;
	assign data_out_o = state.out_bit;
	assign data_out_oe_o = enabled && (master_select_i || !select_n_i);
	assign rx_data_o = state.rx_hold;
	assign tx_empty_flag_o = tx_empty;
	assign rx_full_flag_o = state.rx_full;
	assign tx_underrun_flag_o = state.underrun;
	assign collision_flag_o = state.collision;
	assign slave_abort_flag_o = state.abort;
	assign rx_overrun_flag_o = state.overrun;
	assign select_value_o = state.select_value;
	assign tx_end_of_frame_o = state.end_of_frame;
	assign rx_descriptor_status_o = {1'b0, state.rx_select, state.abort,
		state.overrun};
	assign tx_dma_request_o = tx_empty
		&& (unit_enable_pair_i != PAIR_RX_ONLY);
	assign rx_dma_request_o = state.rx_full
		&& (unit_enable_pair_i != PAIR_TX_ONLY);
	assign tx_dma_done_o = state.done;
	assign rx_dma_done_o = state.done;
	assign irq_o = state.irq;

	////////////////////////////////////////////////////////////////////////
	// checks on the engines and flags
	a_flag_clear_one: assert property (@(posedge clock_i)
		disable iff (reset_i) $fell(state.overrun) |-> $past(clear_overrun_i))
		else $error("overrun cleared without a one written");
	a_framed_underrun: assert property (@(posedge clock_i)
		disable iff (reset_i) char_done && framed && tx_empty
		&& state.engine == ENG_MASTER && !state.frame_last
		|=> state.underrun && !state.select_value)
		else $error("framed underrun missed");
	a_plain_no_under: assert property (@(posedge clock_i)
		disable iff (reset_i) $rose(state.underrun)
		|-> !$past(master_select_i && plain))
		else $error("plain master raised underrun");
	a_slave_ones: assert property (@(posedge clock_i)
		disable iff (reset_i) state.engine == ENG_SLAVE && !select_n_i
		&& sck_rise && state.bit_count == 4'h0 && tx_empty
		&& !(watchdog_run && rate_tick)
		|=> state.shift == ALL_ONES && state.underrun)
		else $error("slave underrun did not send ones");
	a_collision_set: assert property (@(posedge clock_i)
		disable iff (reset_i) enabled && master_select_i
		&& !select_pin_direction_i && !select_n_i |=> state.collision)
		else $error("collision not flagged");
	a_overrun_keep: assert property (@(posedge clock_i)
		disable iff (reset_i) char_done && state.rx_full
		|=> state.rx_hold == $past(state.rx_hold))
		else $error("receive data overwritten on overrun");
	a_abort_idle: assert property (@(posedge clock_i)
		disable iff (reset_i) state.engine == ENG_SLAVE && select_n_i
		&& state.bit_count != 4'h0 && enabled
		|=> state.abort && state.engine == ENG_IDLE)
		else $error("slave abort not taken");
	a_rx_capture: assert property (@(posedge clock_i)
		disable iff (reset_i) char_done && !state.rx_full
		|=> state.rx_full && state.rx_hold == $past(captured))
		else $error("character end did not load receive data");
	a_irq_follows: assert property (@(posedge clock_i)
		disable iff (reset_i) $rose(state.underrun) |=> state.irq)
		else $error("underrun gave no interrupt pulse");
	a_timer_irq: assert property (@(posedge clock_i)
		disable iff (reset_i) timer_run && rate_tick
		|=> state.irq && $stable(state.overrun))
		else $error("timer expiry gave no interrupt");

endmodule : spi_errors_irq_dma

`default_nettype wire

// [tb/far_end.sv]
// far side model: external master clocking the unit, or slave answering it
`default_nettype none

module far_end
(
	input wire logic clock_i,
	input wire logic sck_i,
	input wire logic unit_data_i,
	output logic sck_o,
	output logic select_n_o,
	output logic data_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] reply = 8'h00;
	logic [7:0] seen = 8'h00;
	logic mosi = 1'b0;
	logic slv_out = 1'b0;
	logic driving = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// idle pins: clock low, select high
	initial
	begin
		sck_o = 1'b0;
		select_n_o = 1'b1;
	end

	assign data_o = driving ? mosi : slv_out;

	// slave role: next bit on each rising unit clock
	always @(posedge sck_i)
	begin
		if (!driving)
		begin
			slv_out <= reply[7];
			reply <= {reply[6:0], 1'b0};
		end
	end

	// slave role: capture the unit's bit on each falling clock
	always @(negedge sck_i)
	begin
		if (!driving)
			seen <= {seen[6:0], unit_data_i};
	end

	////////////////////////////////////////////////////////////////////////
	// master role: eight-cycle clock, every gap far below the watchdog
	task automatic send(input logic [7:0] b, input int bits);
		driving = 1'b1;
		select_n_o = 1'b0;
		for (int i = 7; i > 7 - bits; i--)
		begin
			// data moves mid low phase, clear of the falling edge
			repeat (2) @(negedge clock_i);
			mosi = b[i];
			repeat (2) @(negedge clock_i);
			sck_o = 1'b1;
			repeat (4) @(negedge clock_i);
			sck_o = 1'b0;
			seen = {seen[6:0], unit_data_i};
		end
		repeat (4) @(negedge clock_i);
		select_n_o = 1'b1;
		mosi = ~mosi; // released line no longer holds its value
		driving = 1'b0;
	endtask : send

endmodule : far_end

`default_nettype wire

// [tb/spi_errors_irq_dma_tb_top.sv]
// self-checking bench for the serial unit error, interrupt and dma logic
`default_nettype none

module spi_errors_irq_dma_tb_top
	import spi_unit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// positions in the strobe vector
	localparam logic [8:0] WR = 9'h001;
	localparam logic [8:0] RD = 9'h002;
	localparam logic [8:0] SVW = 9'h004;
	localparam logic [8:0] CLR_UNDER = 9'h008;
	localparam logic [8:0] CLR_COLL = 9'h010;
	localparam logic [8:0] CLR_ABORT = 9'h020;
	localparam logic [8:0] CLR_OVER = 9'h040;
	localparam logic [8:0] TX_ACK = 9'h080;
	localparam logic [8:0] RX_ACK = 9'h100;

	logic clock_i = 1'b0;
	logic reset_i;
	logic [1:0] unit_enable_pair_i;
	logic [2:0] protocol_select_field_i;
	logic [7:0] rate_high_i, rate_low_i, tx_data_i, rx_data_o;
	logic master_select_i, select_pin_direction_i, data_irq_enable_i;
	logic rate_timer_control_i, select_value_i, tx_end_of_frame_i;
	logic dma_first_byte_i, dma_select_value_i, dma_end_of_frame_strobe_i;
	logic [8:0] strobe;
	wire logic serial_clock_i, select_n_i, data_in_i, far_sck, far_select_n;
	logic serial_clock_o, serial_clock_oe_o, select_n_o, select_n_oe_o;
	logic data_out_o, data_out_oe_o, tx_empty_flag_o, rx_full_flag_o;
	logic tx_underrun_flag_o, collision_flag_o, slave_abort_flag_o;
	logic rx_overrun_flag_o, select_value_o, tx_end_of_frame_o, irq_o;
	logic tx_dma_request_o, rx_dma_request_o, tx_dma_done_o, rx_dma_done_o;
	logic [3:0] rx_descriptor_status_o;
	int irqs = 0;
	int dones = 0;
	int mismatches = 0;
	int tests_run = 0;

	////////////////////////////////////////////////////////////////////////
	// shared pins: the unit wins where its output enable is high
	assign serial_clock_i = serial_clock_oe_o ? serial_clock_o : far_sck;
	assign select_n_i = select_n_oe_o ? select_n_o : far_select_n;

	spi_errors_irq_dma spi_errors_irq_dma_inst
	(
		.clock_i, .reset_i, .unit_enable_pair_i, .master_select_i,
		.select_pin_direction_i, .protocol_select_field_i,
		.data_irq_enable_i, .rate_timer_control_i, .rate_high_i, .rate_low_i,
		.tx_write_i(strobe[0]), .tx_data_i, .rx_read_i(strobe[1]),
		.select_value_write_i(strobe[2]), .select_value_i, .tx_end_of_frame_i,
		.clear_underrun_i(strobe[3]), .clear_collision_i(strobe[4]),
		.clear_abort_i(strobe[5]), .clear_overrun_i(strobe[6]),
		.tx_dma_ack_i(strobe[7]), .rx_dma_ack_i(strobe[8]),
		.dma_first_byte_i, .dma_select_value_i, .dma_end_of_frame_strobe_i,
		.serial_clock_i, .select_n_i, .data_in_i, .serial_clock_o,
		.serial_clock_oe_o, .select_n_o, .select_n_oe_o, .data_out_o,
		.data_out_oe_o, .rx_data_o, .tx_empty_flag_o, .rx_full_flag_o,
		.tx_underrun_flag_o, .collision_flag_o, .slave_abort_flag_o,
		.rx_overrun_flag_o, .select_value_o, .tx_end_of_frame_o,
		.rx_descriptor_status_o, .tx_dma_request_o, .rx_dma_request_o,
		.tx_dma_done_o, .rx_dma_done_o, .irq_o
	);

	far_end far_end_inst
	(
		.clock_i, .sck_i(serial_clock_i), .unit_data_i(data_out_o),
		.sck_o(far_sck), .select_n_o(far_select_n), .data_o(data_in_i)
	);

	// 200 MHz system clock
	always #2.5 clock_i = ~clock_i;

	// count interrupt and end-of-transaction pulses
	always @(posedge clock_i)
	begin
		if (irq_o === 1'b1)
			irqs++;
		if (rx_dma_done_o === 1'b1 && tx_dma_done_o === 1'b1)
			dones++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc

	// one-cycle strobe, driven after a falling edge
	task automatic pulse(input logic [8:0] s);
		strobe = s;
		cyc(1);
		strobe = '0;
	endtask : pulse

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// bounded wait for a finished character
	task automatic wait_rx;
		int k;
		k = 0;
		while (rx_full_flag_o !== 1'b1 && k < 400)
		begin
			cyc(1);
			k++;
		end
		check("rx wait", k < 400, 1'b1);
	endtask : wait_rx

	// configure with reset held for six cycles, fastest rate
	task automatic setup(input logic [1:0] p, input logic m, d, s,
		input logic [2:0] f);
		reset_i = 1'b1;
		{unit_enable_pair_i, master_select_i, data_irq_enable_i} = {p, m, d};
		select_pin_direction_i = s;
		protocol_select_field_i = f;
		{strobe, select_value_i, tx_end_of_frame_i, dma_first_byte_i} = '0;
		{dma_select_value_i, dma_end_of_frame_strobe_i} = 2'b00;
		{rate_timer_control_i, rate_high_i, rate_low_i} = {1'b0, 16'h0001};
		tx_data_i = 8'h00;
		cyc(6);
		reset_i = 1'b0;
		cyc(2);
	endtask : setup

	////////////////////////////////////////////////////////////////////////
	task automatic t_master;
		int n;
		setup(2'h3, 1'b1, 1'b1, 1'b1, PROTO_PLAIN);
		far_end_inst.reply = 8'h3c;
		check("tx empty", tx_empty_flag_o, 1'b1);
		check("tx request", tx_dma_request_o, 1'b1);
		n = irqs;
		tx_data_i = 8'ha5;
		pulse(WR);
		check("tx empty written", tx_empty_flag_o, 1'b0);
		wait_rx;
		cyc(2);
		check("rx data", rx_data_o, 8'h3c);
		check("msb first", far_end_inst.seen, 8'ha5);
		check("irq pulses", irqs - n, 8'h02);
		far_end_inst.reply = 8'h81;
		tx_data_i = 8'h11;
		pulse(WR);
		cyc(40);
		check("paused rx", rx_data_o, 8'h3c);
		check("no underrun", tx_underrun_flag_o, 1'b0);
		check("no overrun", rx_overrun_flag_o, 1'b0);
		pulse(RD);
		check("rx read", rx_full_flag_o, 1'b0);
		wait_rx;
		check("resumed rx", rx_data_o, 8'h81);
		check("resumed tx", far_end_inst.seen, 8'h11);
		$display("done master plain");
	endtask : t_master

	task automatic t_slave;
		int n;
		setup(2'h3, 1'b0, 1'b0, 1'b0, PROTO_PLAIN);
		n = irqs;
		far_end_inst.send(8'h5a, 8);
		cyc(4);
		check("underrun", tx_underrun_flag_o, 1'b1);
		check("ones out", far_end_inst.seen, ALL_ONES);
		check("rx data", rx_data_o, 8'h5a);
		check("error irq only", irqs - n, 8'h01);
		far_end_inst.send(8'h66, 8);
		cyc(4);
		check("overrun", rx_overrun_flag_o, 1'b1);
		check("old byte", rx_data_o, 8'h5a);
		check("rx status", rx_descriptor_status_o & 4'h9, 4'h1);
		pulse(CLR_UNDER | CLR_OVER);
		cyc(1);
		check("cleared", {tx_underrun_flag_o, rx_overrun_flag_o}, 2'b00);
		$display("done slave errors");
	endtask : t_slave

	task automatic t_tx_only;
		int n;
		setup(PAIR_TX_ONLY, 1'b0, 1'b1, 1'b0, PROTO_PLAIN);
		tx_data_i = 8'hc3;
		pulse(WR);
		n = irqs;
		far_end_inst.send(8'h99, 8);
		cyc(4);
		check("tx only out", far_end_inst.seen, 8'hc3);
		check("tx only irq", irqs - n, 8'h01);
		check("tx only full", rx_full_flag_o, 1'b1);
		check("no rx request", rx_dma_request_o, 1'b0);
		$display("done transmit only");
	endtask : t_tx_only

	task automatic t_abort;
		int n;
		setup(PAIR_RX_ONLY, 1'b0, 1'b0, 1'b0, PROTO_PLAIN);
		check("no tx request", tx_dma_request_o, 1'b0);
		pulse(WR);
		far_end_inst.send(8'h42, 8);
		cyc(4);
		check("rx only ones", far_end_inst.seen, ALL_ONES);
		check("rx request", rx_dma_request_o, 1'b1);
		pulse(RX_ACK);
		check("rx acked", rx_dma_request_o, 1'b0);
		n = dones;
		far_end_inst.send(8'h42, 3);
		cyc(4);
		check("abort", slave_abort_flag_o, 1'b1);
		check("done pulse", dones - n, 8'h01);
		pulse(CLR_ABORT);
		{rate_timer_control_i, rate_low_i} = {1'b1, 8'h14};
		far_end_inst.send(8'h24, 8);
		cyc(4);
		check("rx after abort", rx_data_o, 8'h24);
		check("watchdog fed", slave_abort_flag_o, 1'b0);
		far_end_inst.select_n_o = 1'b0;
		cyc(30);
		check("watchdog expired", slave_abort_flag_o, 1'b1);
		far_end_inst.select_n_o = 1'b1;
		$display("done slave abort");
	endtask : t_abort

	task automatic t_collision;
		int n;
		setup(2'h3, 1'b1, 1'b0, 1'b0, PROTO_PLAIN);
		n = irqs;
		far_end_inst.select_n_o = 1'b0;
		cyc(4);
		check("collision", collision_flag_o, 1'b1);
		check("collision irq", irqs - n, 8'h01);
		pulse(CLR_COLL);
		check("set beats clear", collision_flag_o, 1'b1);
		far_end_inst.select_n_o = 1'b1;
		cyc(2);
		pulse(CLR_COLL);
		cyc(1);
		check("collision cleared", collision_flag_o, 1'b0);
		$display("done collision");
	endtask : t_collision

	task automatic t_framed;
		setup(2'h3, 1'b1, 1'b0, 1'b1, PROTO_AUDIO);
		{dma_first_byte_i, dma_select_value_i, tx_data_i} = {2'b11, 8'h96};
		pulse(TX_ACK);
		dma_first_byte_i = 1'b0;
		check("descriptor select", select_value_o, 1'b1);
		cyc(1);
		check("select pin", select_n_o, 1'b0);
		wait_rx;
		cyc(4);
		check("framed underrun", tx_underrun_flag_o, 1'b1);
		check("select dropped", select_value_o, 1'b0);
		check("clock halted", serial_clock_o, 1'b0);
		check("rx select", rx_descriptor_status_o, 4'h4);
		pulse(RX_ACK | CLR_UNDER);
		{select_value_i, tx_end_of_frame_i} = 2'b10;
		cyc(1);
		pulse(SVW);
		{dma_end_of_frame_strobe_i, tx_data_i} = {1'b1, 8'h3c};
		cyc(1);
		pulse(TX_ACK);
		dma_end_of_frame_strobe_i = 1'b0;
		check("end of frame", tx_end_of_frame_o, 1'b1);
		wait_rx;
		cyc(4);
		check("eof no underrun", tx_underrun_flag_o, 1'b0);
		check("eof clears", {select_value_o, tx_end_of_frame_o}, 2'b00);
		$display("done framed master");
	endtask : t_framed

	task automatic t_timer;
		int n;
		setup(PAIR_OFF, 1'b0, 1'b0, 1'b0, PROTO_PLAIN);
		rate_low_i = 8'h05;
		cyc(1);
		rate_timer_control_i = 1'b1;
		cyc(20);
		n = irqs;
		cyc(25);
		check("timer pulses", irqs - n, 8'h05);
		check("no flags", {tx_empty_flag_o, rx_full_flag_o, tx_underrun_flag_o,
			collision_flag_o, slave_abort_flag_o, rx_overrun_flag_o}, 6'h00);
		rate_timer_control_i = 1'b0;
		cyc(2);
		n = irqs;
		cyc(20);
		check("timer off", irqs - n, 8'h00);
		$display("done timer");
	endtask : t_timer

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// main sequence
	initial
	begin
		t_master;
		t_slave;
		t_tx_only;
		t_abort;
		t_collision;
		t_framed;
		t_timer;
		end_of_test;
	end

	// watchdog: tests need under a thousand cycles, this allows 20000
	initial
	begin
		#100000;
		mismatches++;
		end_of_test;
	end

endmodule : spi_errors_irq_dma_tb_top

`default_nettype wire
